// ==== nand_ecc_regs.vh ====
// Constants shared by the NAND error-correction generator files.
// What this block does
// - One-bit parity per NAND chip select, 512 bytes.
// - Reading one-bit result clears its start bit.
// - Writing start one clears that one-bit result.
// - Column and row parities packed per bus width.
// - Four-bit engine serves 8-bit NAND only.
// - Four-bit start serves one chosen chip select.
// - Parity after writes, syndrome after reads, readable.
// - Result read clears start; start clears results.
// - Ten-bit symbols, top two bits zero.
// - All-zero syndrome means no bit errors.
// - Locate start computes addresses, values, then state.
// - Error count, four address, four value registers.
// - Error register read clears locate start bit.
// - Syndrome captured so new reads run concurrently.
// - Four-bit engine accumulates up to 518 bytes.
`ifndef NAND_ECC_REGS_VH
`define NAND_ECC_REGS_VH

`define CS_COUNT 4
`define ONE_BIT_RES_W 24
`define ONE_BIT_IDX_W 9
`define ONE_BIT_IDX_STEP 9'h001
`define SYM_PAD 2'h0
`define FOUR_BIT_MAX_BYTES 10'h206
`define ECC_MAX_DEGREE 10'h20D
`define ECC_SCAN_END 10'h20E
`define GF_POLY 10'h009
`define GF_ONE 10'h001
`define GF_ALPHA 10'h002
`define BM_LAST 10'h007
`define OMEGA_LAST 10'h003
`define MAX_ERRORS 3'h4
`define ERR_DEG_MAX 4'h4
`define INV_STEPS 4'h9
`define ECC_ST_BUSY 4'h0
`define ECC_ST_NONE 4'h1
`define ECC_ST_FIXABLE 4'h2
`define ECC_ST_UNFIXABLE 4'h3

`endif

// ==== one_bit_beat_parity.v ====
// Hamming parity contribution of one data beat to the one-bit result.
`timescale 1ns/1ns
`include "nand_ecc_regs.vh"

module one_bit_beat_parity (
    // Beat and its position
    input wire [15:0] data,
    input wire [8:0] index,
    input wire wide,
    // Parity flips {odd levels, even levels}
    output wire [23:0] flip
);

    wire [12*17-1:0] odd_chain;
    wire [12*17-1:0] even_chain;

    assign odd_chain[11:0] = 12'h000;
    assign even_chain[11:0] = 12'h000;

    // Each data bit has a 12-bit position; level j toggles odd or even by bit j.
    genvar k;
    generate
        for (k = 0; k < 16; k = k + 1) begin : bitpos
            localparam [3:0] BIT_ID = k;
            wire live = data[k] & (wide | ~BIT_ID[3]);
            wire [11:0] pos = wide ? {index[7:0], BIT_ID} : {index, BIT_ID[2:0]};
            assign odd_chain[12*(k+1) +: 12] = odd_chain[12*k +: 12] ^ (pos & {12{live}});
            assign even_chain[12*(k+1) +: 12] = even_chain[12*k +: 12] ^ (~pos & {12{live}});
        end
    endgenerate

    assign flip = {odd_chain[12*16 +: 12], even_chain[12*16 +: 12]};

endmodule // one_bit_beat_parity

// ==== gf10_inverter.v ====
// Sequential inverse in GF(2^10) by repeated squaring.
`timescale 1ns/1ns
`include "nand_ecc_regs.vh"

module gf10_inverter (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Request
    input wire start,
    input wire [9:0] operand,
    // Answer
    output reg done,
    output reg [9:0] result
);

    reg [9:0] sq_r;
    reg [3:0] cnt_r;
    reg busy_r;
    wire [9:0] sq_nxt;

    function [9:0] gf_mul;
        input [9:0] a;
        input [9:0] b;
        reg [9:0] p;
        integer i;
        begin
            p = 10'h000;
            for (i = 9; i >= 0; i = i - 1) begin
                p = {p[8:0], 1'b0} ^ (p[9] ? `GF_POLY : 10'h000);
                if (b[i])
                    p = p ^ a;
            end
            gf_mul = p;
        end
    endfunction

    assign sq_nxt = gf_mul(sq_r, sq_r);

    // The product of a^2 .. a^512 is a^1022, the inverse; a zero operand yields zero.
    always @(posedge clock) begin
        if (!resetn) begin
            sq_r <= 10'h000;
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            done <= 1'b0;
            result <= 10'h000;
        end else begin
            done <= 1'b0;
            if (start) begin
                sq_r <= operand;
                result <= `GF_ONE;
                cnt_r <= 4'h0;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                sq_r <= sq_nxt;
                result <= gf_mul(result, sq_nxt);
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == `INV_STEPS - 4'h1) begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule // gf10_inverter

// ==== nand_ecc_generator.v ====
// One-bit Hamming and four-bit symbol ECC engines for NAND transfers.
`timescale 1ns/1ns
`include "nand_ecc_regs.vh"

module nand_ecc_generator (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Observed data beats to the NAND chip selects
    input wire beat_valid,
    input wire beat_write,
    input wire [1:0] beat_cs,
    input wire [15:0] beat_data,
    input wire bus_16bit,
    // Control fields and access strobes
    input wire [3:0] nand_mode_select,
    input wire [3:0] one_bit_ecc_start_set,
    input wire [3:0] one_bit_result_rd,
    input wire [1:0] four_bit_cs_choice,
    input wire four_bit_start_set,
    input wire four_bit_result_rd,
    input wire parity_load_wr,
    input wire [9:0] parity_load_data,
    input wire error_locate_set,
    input wire error_reg_rd,
    // One-bit status and results
    output wire [3:0] one_bit_ecc_start,
    output wire [95:0] one_bit_ecc_result,
    // Four-bit status and results
    output wire four_bit_calc_start,
    output wire [79:0] four_bit_result_regs,
    output wire error_locate_start,
    output wire [3:0] ecc_state,
    output wire [2:0] error_count,
    output wire [39:0] error_address_regs,
    output wire [39:0] error_value_regs
);

    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_BM = 6'h02;
    localparam [5:0] ST_OMEGA = 6'h04;
    localparam [5:0] ST_CHIEN = 6'h08;
    localparam [5:0] ST_INV_GO = 6'h10;
    localparam [5:0] ST_INV_WAIT = 6'h20;

    function [9:0] gf_mul;
        input [9:0] a;
        input [9:0] b;
        reg [9:0] p;
        integer i;
        begin
            p = 10'h000;
            for (i = 9; i >= 0; i = i - 1) begin
                p = {p[8:0], 1'b0} ^ (p[9] ? `GF_POLY : 10'h000);
                if (b[i])
                    p = p ^ a;
            end
            gf_mul = p;
        end
    endfunction

    function [9:0] gf_pow;
        input integer e;
        reg [9:0] p;
        integer i;
        begin
            p = `GF_ONE;
            for (i = 0; i < e; i = i + 1)
                p = gf_mul(p, `GF_ALPHA);
            gf_pow = p;
        end
    endfunction

    // Generator with roots alpha^1..alpha^8; the monic top term is implied.
    function [79:0] gen_poly;
        input dummy;
        reg [89:0] g;
        reg [9:0] a;
        integer i;
        integer k;
        begin
            g = {80'h0, `GF_ONE};
            a = `GF_ONE;
            for (i = 1; i <= 8; i = i + 1) begin
                a = gf_mul(a, `GF_ALPHA);
                for (k = 8; k >= 0; k = k - 1) begin
                    if (k > 0)
                        g[10*k +: 10] = g[10*(k-1) +: 10] ^ gf_mul(g[10*k +: 10], a);
                    else
                        g[9:0] = gf_mul(g[9:0], a);
                end
            end
            gen_poly = g[79:0];
        end
    endfunction

    localparam [79:0] GEN = gen_poly(1'b0);
    localparam [39:0] ALPHA_INV = {gf_pow(1019), gf_pow(1020), gf_pow(1021), gf_pow(1022)};

    // One-bit engines, one per chip select.
    wire [23:0] beat_flip;
    wire [35:0] idx_flat;
    wire [8:0] beat_idx = idx_flat[beat_cs * `ONE_BIT_IDX_W +: 9];

    one_bit_beat_parity u_beat_parity (
        .data(beat_data),
        .index(beat_idx),
        .wide(bus_16bit),
        .flip(beat_flip)
    );

    genvar n;
    generate
        for (n = 0; n < `CS_COUNT; n = n + 1) begin : one_cs
            localparam [1:0] CS_ID = n;
            reg start_r;
            reg [23:0] res_r;
            reg [8:0] idx_r;
            wire hit = beat_valid && (beat_cs == CS_ID) && nand_mode_select[n] && start_r;
            // A start written in the same cycle as a read keeps the engine armed.
            always @(posedge clock) begin
                if (!resetn) begin
                    start_r <= 1'b0;
                    res_r <= 24'h000000;
                    idx_r <= 9'h000;
                end else if (one_bit_ecc_start_set[n]) begin
                    start_r <= 1'b1;
                    res_r <= 24'h000000;
                    idx_r <= 9'h000;
                end else begin
                    if (one_bit_result_rd[n])
                        start_r <= 1'b0;
                    if (hit) begin
                        res_r <= res_r ^ beat_flip;
                        idx_r <= idx_r + `ONE_BIT_IDX_STEP;
                    end
                end
            end
            assign one_bit_ecc_start[n] = start_r;
            assign one_bit_ecc_result[24*n +: 24] = res_r;
            assign idx_flat[9*n +: 9] = idx_r;
        end
    endgenerate

    // Four-bit accumulation: parity remainder for writes, syndromes for reads.
    reg four_start_r;
    reg [79:0] syn_r;
    reg [79:0] rem_r;
    reg [79:0] four_res_r;
    reg [9:0] sym_cnt_r;
    reg wrote_r;
    wire [9:0] sym = {`SYM_PAD, beat_data[7:0]};
    wire four_hit = beat_valid && four_start_r && !bus_16bit
        && (beat_cs == four_bit_cs_choice) && nand_mode_select[four_bit_cs_choice]
        && (sym_cnt_r < `FOUR_BIT_MAX_BYTES);
    wire [9:0] horner_in = four_hit ? sym : parity_load_data;
    wire [9:0] fb = sym ^ rem_r[79:70];
    wire [89:0] rem_shift = {rem_r, 10'h000};
    wire [79:0] syn_nxt;
    wire [79:0] rem_nxt;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : sym_slice
            localparam [9:0] APOW = `GF_ALPHA << i;
            assign syn_nxt[10*i +: 10] = gf_mul(syn_r[10*i +: 10], APOW) ^ horner_in;
            assign rem_nxt[10*i +: 10] = rem_shift[10*i +: 10] ^ gf_mul(fb, GEN[10*i +: 10]);
        end
    endgenerate

    always @(posedge clock) begin
        if (!resetn) begin
            four_start_r <= 1'b0;
            syn_r <= 80'h0;
            rem_r <= 80'h0;
            sym_cnt_r <= 10'h000;
            wrote_r <= 1'b0;
            four_res_r <= 80'h0;
        end else begin
            four_res_r <= four_bit_start_set ? 80'h0 : (wrote_r ? rem_r : syn_r);
            if (four_bit_start_set) begin
                four_start_r <= 1'b1;
                syn_r <= 80'h0;
                rem_r <= 80'h0;
                sym_cnt_r <= 10'h000;
                wrote_r <= 1'b0;
            end else begin
                if (four_bit_result_rd)
                    four_start_r <= 1'b0;
                if (four_hit) begin
                    rem_r <= rem_nxt;
                    sym_cnt_r <= sym_cnt_r + 10'h001;
                    wrote_r <= beat_write;
                end else if (parity_load_wr) begin
                    wrote_r <= 1'b0;
                end
                if (four_hit || parity_load_wr)
                    syn_r <= syn_nxt;
            end
        end
    end

    // Error location: Berlekamp-Massey, Chien search, Forney values.
    reg [5:0] st_r;
    reg [79:0] scap_r;
    reg [49:0] lam_r;
    reg [49:0] bp_r;
    reg [9:0] gam_r;
    reg [3:0] deg_r;
    reg [9:0] step_r;
    reg [39:0] om_r;
    reg [39:0] chl_r;
    reg [29:0] cho_r;
    reg [9:0] xinv_r;
    reg [2:0] found_r;
    reg [2:0] vidx_r;
    reg [39:0] num_r;
    reg [39:0] den_r;
    reg [39:0] addr_r;
    reg [39:0] val_r;
    reg [3:0] state_out_r;
    reg [2:0] count_r;
    reg loc_start_r;
    reg inv_go_r;
    reg [9:0] dot;
    reg [9:0] chien_sum;
    reg [9:0] oval;
    reg [49:0] lam_upd;
    wire [49:0] bpx = {bp_r[39:0], 10'h000};
    wire syn_zero = (syn_r == 80'h0);
    wire inv_done;
    wire [9:0] inv_res;
    integer j, q;

    gf10_inverter u_inverter (
        .clock(clock),
        .resetn(resetn),
        .start(inv_go_r),
        .operand(den_r[10*vidx_r +: 10]),
        .done(inv_done),
        .result(inv_res)
    );

    always @* begin
        dot = 10'h000;
        chien_sum = lam_r[9:0];
        oval = om_r[9:0];
        lam_upd = 50'h0;
        for (j = 0; j < 5; j = j + 1) begin
            if (step_r[2:0] >= j)
                dot = dot ^ gf_mul(lam_r[10*j +: 10], scap_r[10*(step_r[2:0]-j) +: 10]);
        end
        for (j = 0; j < 5; j = j + 1)
            lam_upd[10*j +: 10] = gf_mul(gam_r, lam_r[10*j +: 10]) ^ gf_mul(dot, bpx[10*j +: 10]);
        for (j = 0; j < 4; j = j + 1)
            chien_sum = chien_sum ^ chl_r[10*j +: 10];
        for (j = 0; j < 3; j = j + 1)
            oval = oval ^ cho_r[10*j +: 10];
    end

    always @(posedge clock) begin
        if (!resetn) begin
            st_r <= ST_IDLE;
            scap_r <= 80'h0;
            lam_r <= 50'h0;
            bp_r <= 50'h0;
            gam_r <= 10'h000;
            deg_r <= 4'h0;
            step_r <= 10'h000;
            om_r <= 40'h0;
            chl_r <= 40'h0;
            cho_r <= 30'h0;
            xinv_r <= 10'h000;
            found_r <= 3'h0;
            vidx_r <= 3'h0;
            num_r <= 40'h0;
            den_r <= 40'h0;
            addr_r <= 40'h0;
            val_r <= 40'h0;
            state_out_r <= `ECC_ST_BUSY;
            count_r <= 3'h0;
            loc_start_r <= 1'b0;
            inv_go_r <= 1'b0;
        end else begin
            inv_go_r <= 1'b0;
            if (error_locate_set)
                loc_start_r <= 1'b1;
            else if (error_reg_rd)
                loc_start_r <= 1'b0;
            if (error_locate_set) begin
                // The working copy frees the accumulator for the next read.
                scap_r <= syn_r;
                lam_r <= {40'h0, `GF_ONE};
                bp_r <= {40'h0, `GF_ONE};
                gam_r <= `GF_ONE;
                deg_r <= 4'h0;
                step_r <= 10'h000;
                found_r <= 3'h0;
                count_r <= 3'h0;
                addr_r <= 40'h0;
                val_r <= 40'h0;
                state_out_r <= syn_zero ? `ECC_ST_NONE : `ECC_ST_BUSY;
                st_r <= syn_zero ? ST_IDLE : ST_BM;
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        st_r <= ST_IDLE;
                    end
                    ST_BM: begin
                        lam_r <= lam_upd;
                        if ((dot != 10'h000) && ({deg_r, 1'b0} <= step_r)) begin
                            bp_r <= lam_r;
                            deg_r <= step_r[3:0] + 4'h1 - deg_r;
                            gam_r <= dot;
                        end else begin
                            bp_r <= bpx;
                        end
                        step_r <= (step_r == `BM_LAST) ? 10'h000 : step_r + 10'h001;
                        if (step_r == `BM_LAST)
                            st_r <= ST_OMEGA;
                    end
                    ST_OMEGA: begin
                        om_r[10*step_r[1:0] +: 10] <= dot;
                        step_r <= step_r + 10'h001;
                        if (step_r == `OMEGA_LAST) begin
                            step_r <= 10'h000;
                            chl_r <= lam_r[49:10];
                            cho_r <= {dot, om_r[29:10]};
                            xinv_r <= `GF_ONE;
                            if (deg_r > `ERR_DEG_MAX) begin
                                state_out_r <= `ECC_ST_UNFIXABLE;
                                st_r <= ST_IDLE;
                            end else begin
                                st_r <= ST_CHIEN;
                            end
                        end
                    end
                    ST_CHIEN: begin
                        if (step_r == `ECC_SCAN_END) begin
                            vidx_r <= 3'h0;
                            if ((found_r != 3'h0) && ({1'b0, found_r} == deg_r)) begin
                                st_r <= ST_INV_GO;
                            end else begin
                                state_out_r <= `ECC_ST_UNFIXABLE;
                                st_r <= ST_IDLE;
                            end
                        end else begin
                            // A root at degree i marks the word total + 7 - i.
                            if ((chien_sum == 10'h000) && (found_r < `MAX_ERRORS)) begin
                                addr_r[10*found_r +: 10] <= step_r;
                                num_r[10*found_r +: 10] <= gf_mul(oval, xinv_r);
                                den_r[10*found_r +: 10] <= chl_r[9:0] ^ chl_r[29:20];
                                found_r <= found_r + 3'h1;
                            end
                            for (q = 0; q < 4; q = q + 1)
                                chl_r[10*q +: 10] <= gf_mul(chl_r[10*q +: 10], ALPHA_INV[10*q +: 10]);
                            for (q = 0; q < 3; q = q + 1)
                                cho_r[10*q +: 10] <= gf_mul(cho_r[10*q +: 10], ALPHA_INV[10*q +: 10]);
                            xinv_r <= gf_mul(xinv_r, ALPHA_INV[9:0]);
                            step_r <= step_r + 10'h001;
                        end
                    end
                    ST_INV_GO: begin
                        inv_go_r <= 1'b1;
                        st_r <= ST_INV_WAIT;
                    end
                    ST_INV_WAIT: begin
                        if (inv_done) begin
                            val_r[10*vidx_r +: 10] <= gf_mul(num_r[10*vidx_r +: 10], inv_res);
                            if (vidx_r + 3'h1 == found_r) begin
                                state_out_r <= `ECC_ST_FIXABLE;
                                count_r <= found_r;
                                st_r <= ST_IDLE;
                            end else begin
                                vidx_r <= vidx_r + 3'h1;
                                st_r <= ST_INV_GO;
                            end
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign four_bit_calc_start = four_start_r;
    assign four_bit_result_regs = four_res_r;
    assign error_locate_start = loc_start_r;
    assign ecc_state = state_out_r;
    assign error_count = count_r;
    assign error_address_regs = addr_r;
    assign error_value_regs = val_r;

endmodule // nand_ecc_generator

// ==== nand_ecc_generator_asserts.sv ====
// Concurrent checks on the NAND ECC generator ports.
`timescale 1ns/1ns
module nand_ecc_checker (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Beats and strobes
    input wire beat_valid,
    input wire [3:0] one_bit_ecc_start_set,
    input wire [3:0] one_bit_result_rd,
    input wire four_bit_start_set,
    input wire four_bit_result_rd,
    input wire error_locate_set,
    input wire error_reg_rd,
    // Status and results
    input wire [3:0] one_bit_ecc_start,
    input wire [95:0] one_bit_ecc_result,
    input wire four_bit_calc_start,
    input wire [79:0] four_bit_result_regs,
    input wire error_locate_start,
    input wire [3:0] ecc_state
);
    localparam int LOC_MAX = 600;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence loc_go;
        error_locate_set;
    endsequence
    sequence loc_done;
        ecc_state != 4'h0;
    endsequence
    start_clears_a: assert property (one_bit_ecc_start_set[1] |=>
        one_bit_ecc_start[1] && one_bit_ecc_result[47:24] == 24'h0)
        else $error("one-bit start left old result");
    read_clears_a: assert property (one_bit_result_rd[1] && !one_bit_ecc_start_set[1]
        |=> !one_bit_ecc_start[1]) else $error("one-bit read kept start");
    idle_holds_a: assert property (!beat_valid && one_bit_ecc_start_set == 4'h0
        |=> $stable(one_bit_ecc_result)) else $error("one-bit result moved without beat");
    four_read_a: assert property (four_bit_result_rd && !four_bit_start_set
        |=> !four_bit_calc_start) else $error("four-bit read kept start");
    four_start_a: assert property (four_bit_start_set |=>
        four_bit_calc_start && four_bit_result_regs == 80'h0)
        else $error("four-bit start left results");
    zero_syndrome_a: assert property (loc_go and four_bit_result_regs == 80'h0
        |=> ecc_state == 4'h1) else $error("zero syndrome not reported clean");
    locate_bound_a: assert property (loc_go |-> ##[1:LOC_MAX] loc_done)
        else $error("error location did not finish");
    err_read_a: assert property (error_reg_rd && !error_locate_set
        |=> !error_locate_start) else $error("error read kept locate start");
endmodule // nand_ecc_checker

bind nand_ecc_generator nand_ecc_checker u_nand_ecc_checker (
    .clock, .resetn, .beat_valid, .one_bit_ecc_start_set, .one_bit_result_rd,
    .four_bit_start_set, .four_bit_result_rd, .error_locate_set, .error_reg_rd,
    .one_bit_ecc_start, .one_bit_ecc_result, .four_bit_calc_start,
    .four_bit_result_regs, .error_locate_start, .ecc_state);

// ==== nand_flash_model.sv ====
// Behavioural NAND flash that sinks written bytes and sources read bytes.
`timescale 1ns/1ns
module nand_flash_model (
    // Clock
    input wire clock,
    // Transfer request
    input wire run,
    input wire wr,
    input wire [9:0] count,
    input wire [7:0] seed,
    input wire [9:0] flip_idx,
    // Bus beats
    output reg beat_valid,
    output reg beat_write,
    output reg [15:0] beat_data,
    output reg busy
);
    reg [7:0] mem [0:1023];
    reg [9:0] n;
    wire [7:0] pat = n[7:0] * 8'h03 ^ seed;
    initial begin
        beat_valid = 1'b0;
        beat_write = 1'b0;
        beat_data = 16'h0000;
        busy = 1'b0;
        n = 10'h000;
    end
    // Idle data lines toggle, so a stale byte never passes for a fresh one.
    always @(negedge clock) begin
        beat_valid <= 1'b0;
        beat_data <= ~beat_data;
        if (busy && n == count) begin
            busy <= 1'b0;
        end else if (busy) begin
            beat_valid <= 1'b1;
            beat_data <= {8'h00, wr ? pat : mem[n] ^ (n == flip_idx ? 8'h24 : 8'h00)};
            if (wr) mem[n] <= pat;
            n <= n + 10'h001;
        end else if (run) begin
            busy <= 1'b1;
            beat_write <= wr;
            n <= 10'h000;
        end
    end
endmodule // nand_flash_model

// ==== tb_nand_ecc_generator.sv ====
// Self-checking bench for the NAND ECC generator.
`timescale 1ns/1ns
module tb_nand_ecc_generator;
    reg clock = 1'b0;
    reg resetn = 1'b0;
    reg [12:0] stb = 13'h0000;
    reg [3:0] mode = 4'h7;
    reg [1:0] cs = 2'h1;
    reg [1:0] choice = 2'h2;
    reg [9:0] pload = 10'h000;
    reg run = 1'b0;
    reg wr = 1'b0;
    reg [9:0] cnt = 10'h000;
    reg [7:0] seed = 8'h00;
    reg [9:0] flip = 10'h3FF;
    reg wide = 1'b0;
    reg [79:0] par;
    integer errors = 0;
    integer compares = 0;
    integer k;
    wire beat_valid, beat_write, busy, four_bit_calc_start, error_locate_start;
    wire [15:0] beat_data;
    wire [3:0] one_bit_ecc_start, ecc_state;
    wire [95:0] one_bit_ecc_result;
    wire [79:0] four_bit_result_regs;
    wire [2:0] error_count;
    wire [39:0] error_address_regs, error_value_regs;
    nand_ecc_generator u_nand_ecc_generator (
        .clock, .resetn, .beat_valid, .beat_write, .beat_cs(cs), .beat_data,
        .bus_16bit(wide), .nand_mode_select(mode), .one_bit_ecc_start_set(stb[3:0]),
        .one_bit_result_rd(stb[7:4]), .four_bit_cs_choice(choice),
        .four_bit_start_set(stb[8]), .four_bit_result_rd(stb[9]), .parity_load_wr(stb[10]),
        .parity_load_data(pload), .error_locate_set(stb[11]), .error_reg_rd(stb[12]),
        .one_bit_ecc_start, .one_bit_ecc_result, .four_bit_calc_start, .four_bit_result_regs,
        .error_locate_start, .ecc_state, .error_count, .error_address_regs, .error_value_regs);
    nand_flash_model u_nand_flash_model (.clock, .run, .wr, .count(cnt), .seed,
        .flip_idx(flip), .beat_valid, .beat_write, .beat_data, .busy);
    initial begin
        forever #20 clock = ~clock;
    end
    task chk(input [95:0] seen, input [95:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    task st(input [12:0] m);
        begin
            @(negedge clock) stb <= m;
            @(negedge clock) stb <= 13'h0000;
            repeat (2) @(negedge clock);
        end
    endtask
    task xfer(input w, input [9:0] c, input [7:0] s, input [9:0] f);
        begin
            @(negedge clock);
            wr <= w;
            cnt <= c;
            seed <= s;
            flip <= f;
            run <= 1'b1;
            @(negedge clock) run <= 1'b0;
            @(negedge clock);
            for (k = 0; k < 2000 && busy; k = k + 1) @(negedge clock);
            repeat (3) @(negedge clock);
        end
    endtask
    task load_par;
        integer i;
        begin
            for (i = 8; i > 0; i = i - 1) begin
                pload <= par[i * 10 - 1 -: 10];
                st(13'h0400);
            end
            repeat (3) @(negedge clock);
        end
    endtask
    task wait_state;
        begin
            for (k = 0; k < 700 && ecc_state === 4'h0; k = k + 1) @(negedge clock);
        end
    endtask
    // Odd parities sit in the upper half, level 2^j at bit j of each half.
    function [23:0] obpar(input [9:0] c, input [7:0] s);
        reg [23:0] p;
        reg [7:0] v;
        reg [11:0] pos;
        integer i, b, j;
        begin
            p = 24'h000000;
            for (i = 0; i < c; i = i + 1) begin
                v = i[7:0] * 8'h03 ^ s;
                for (b = 0; b < 8; b = b + 1) begin
                    pos = {i[8:0], b[2:0]};
                    for (j = 0; j < 12; j = j + 1) begin
                        if (v[b] && pos[j]) p[12 + j] = ~p[12 + j];
                        if (v[b] && !pos[j]) p[j] = ~p[j];
                    end
                end
            end
            obpar = p;
        end
    endfunction
    task finish_test;
        begin
            $display("Counts: %0d compares, %0d errors", compares, errors);
            if (errors == 0 && compares > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #400000;
        errors = errors + 1;
        finish_test;
    end
    initial begin
        repeat (3) @(negedge clock);
        resetn <= 1'b1;
        st(13'h0002);
        chk(one_bit_ecc_start, 4'h2);
        xfer(1'b1, 10'h040, 8'h5A, 10'h3FF);
        chk(one_bit_ecc_result, {48'h0, obpar(10'h040, 8'h5A), 24'h0});
        chk(one_bit_ecc_result[47:45], 3'h0);
        st(13'h0020);
        chk(one_bit_ecc_start, 4'h0);
        st(13'h000A);
        cs <= 2'h3;
        xfer(1'b1, 10'h008, 8'h11, 10'h3FF);
        chk(one_bit_ecc_result, 96'h0);
        cs <= 2'h1;
        xfer(1'b1, 10'h200, 8'hC3, 10'h3FF);
        chk(one_bit_ecc_result, {48'h0, obpar(10'h200, 8'hC3), 24'h0});
        $display("one-bit test done");
        cs <= 2'h2;
        st(13'h0100);
        chk(four_bit_result_regs, 80'h0);
        xfer(1'b1, 10'h206, 8'h37, 10'h3FF);
        par = four_bit_result_regs;
        st(13'h0200);
        chk(four_bit_calc_start, 1'b0);
        st(13'h0100);
        cs <= 2'h1;
        xfer(1'b1, 10'h010, 8'h99, 10'h3FF);
        cs <= 2'h2;
        wide <= 1'b1;
        xfer(1'b1, 10'h010, 8'h99, 10'h3FF);
        wide <= 1'b0;
        xfer(1'b1, 10'h208, 8'h37, 10'h3FF);
        chk(four_bit_result_regs, par);
        $display("four-bit write test done");
        st(13'h0100);
        xfer(1'b0, 10'h206, 8'h37, 10'h3FF);
        st(13'h0200);
        load_par;
        chk(four_bit_result_regs, 80'h0);
        st(13'h0800);
        wait_state;
        chk(ecc_state, 4'h1);
        st(13'h0100);
        xfer(1'b0, 10'h206, 8'h37, 10'h064);
        st(13'h0200);
        load_par;
        st(13'h0800);
        st(13'h0100);
        xfer(1'b0, 10'h206, 8'h37, 10'h3FF);
        wait_state;
        chk(ecc_state, 4'h2);
        chk(error_count, 3'h1);
        chk(error_address_regs[9:0], 10'h1A9);
        chk(error_value_regs[9:0], 10'h024);
        st(13'h1000);
        chk(error_locate_start, 1'b0);
        st(13'h0200);
        load_par;
        chk(four_bit_result_regs, 80'h0);
        $display("four-bit read test done");
        finish_test;
    end
endmodule // tb_nand_ecc_generator
